// ---- include/qdac_pkg.sv ----
// package for the quad converter serial word loader
// assumes a 32-bit register bus and a 16-bit serial word
package qdac_pkg;
  ////////////////////////////////////////////////////////////////////
  // serial word layout
  localparam int unsigned QDAC_WORD_BITS = 16;
  localparam int unsigned QDAC_CNT_BITS = 5;
  localparam logic [4:0] QDAC_CNT_FULL = 5'h10;
  localparam logic [4:0] QDAC_CNT_LAST = 5'h0F;
  localparam int unsigned QDAC_SEL_HI = 15;
  localparam int unsigned QDAC_SEL_LO = 14;
  localparam int unsigned QDAC_GAIN_BIT = 13;
  localparam int unsigned QDAC_BUF_BIT = 12;
  localparam int unsigned QDAC_CODE_MSB = 11;
  localparam int unsigned QDAC_CODE_BITS = 12;
  localparam int unsigned QDAC_CHANNELS = 4;
  ////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] QDAC_CTRL_OFS = 8'h00;
  localparam logic [7:0] QDAC_STAT_OFS = 8'h04;
  localparam logic [7:0] QDAC_INREG_OFS = 8'h10;
  localparam logic [7:0] QDAC_DACREG_OFS = 8'h20;
  localparam logic [7:0] QDAC_BANK_MASK = 8'hF0;
  // field positions
  localparam int unsigned QDAC_CTRL_PD_BIT = 0;
  localparam int unsigned QDAC_CTRL_LOAD_BIT = 1;
  localparam int unsigned QDAC_STAT_PD_BIT = 0;
  localparam int unsigned QDAC_STAT_LOAD_BIT = 1;
  localparam int unsigned QDAC_STAT_CNT_LSB = 8;
  // reset values
  localparam logic [31:0] QDAC_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] QDAC_PIN_RST = 2'h3;
  // bus answers
  localparam logic [1:0] QDAC_RESP_OKAY = 2'h0;
  localparam logic [1:0] QDAC_RESP_SLVERR = 2'h2;
  ////////////////////////////////////////////////////////////////////
  // one channel: same bit order as the low 14 bits of a word
  typedef struct packed {
    logic gain;        // 1: twice the reference range
    logic buf_en;      // 1: buffered reference
    logic [11:0] code; // unsigned binary code
  } qdac_chan_t;
endpackage

// ---- design/qdac_sync2.sv ----
// two-flop level synchroniser, one bit per lane
// assumes inputs are levels or toggles from another clock domain
`timescale 1ns/1ps
module qdac_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,              // destination clock
  input wire logic sys_rst,          // async reset, active high
  input wire logic [W-1:0] d_i,      // foreign levels
  output logic [W-1:0] q_o           // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2; // second stage
  } qdac_sync_t;
  qdac_sync_t st_r;
  qdac_sync_t st_nxt;
  if (W < 1) begin : g_bad_w
    $error("qdac_sync2: W must be at least 1");
  end
  ////////////////////////////////////////////////////////////////////
  // next state: plain shift through both stages
  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_o = st_r.s2;
endmodule // qdac_sync2

// ---- design/qdac_link_rx.sv ----
// serial receiver on the link clock: shifts words on falling edges
// assumes the host raises frame select between frames
`timescale 1ns/1ps
module qdac_link_rx
  import qdac_pkg::*;
(
  input wire logic sclk,                 // serial clock from host
  input wire logic sys_rst,              // async reset, active high
  input wire logic frame_sel_n,          // frame select, active low
  input wire logic sdata,                // serial data in
  output logic [15:0] word_o,            // last complete word
  output logic done_tog_o                // toggles per complete word
);
  typedef struct packed {
    logic [4:0] cnt;    // falling edges seen in this frame
    logic [15:0] shift; // partial word
  } qdac_frame_t;
  typedef struct packed {
    logic [15:0] word;  // held until the next complete word
    logic tog;          // event toggle for the crossing
  } qdac_done_t;
  qdac_frame_t fr_r;
  qdac_frame_t fr_nxt;
  qdac_done_t dn_r;
  qdac_done_t dn_nxt;
  logic frame_rst;
  ////////////////////////////////////////////////////////////////////
  // frame select high wipes the partial word, so an early release
  // leaves nothing behind (R14)
  assign frame_rst = sys_rst | frame_sel_n;
  // next state: shift msb first, stop after sixteen edges
  always_comb begin
    fr_nxt = fr_r;
    dn_nxt = dn_r;
    if (fr_r.cnt != QDAC_CNT_FULL) begin
      fr_nxt.shift = {fr_r.shift[14:0], sdata}; // R13 R1
      fr_nxt.cnt = fr_r.cnt + 5'h01;
    end
    // sixteenth edge: whole word captured before any decoding (R1)
    if (fr_r.cnt == QDAC_CNT_LAST) begin
      dn_nxt.word = {fr_r.shift[14:0], sdata};
      dn_nxt.tog = ~dn_r.tog;
    end
  end
  // partial frame state, cleared whenever frame select is high
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end
  // completed word survives the end of the frame
  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      dn_r <= '0;
    end else begin
      dn_r <= dn_nxt;
    end
  end
  assign word_o = dn_r.word;
  assign done_tog_o = dn_r.tog;
endmodule // qdac_link_rx

// ---- design/qdac_loader.sv ----
// quad converter serial word loader: input and converter registers,
// load and power-down control, register access over AXI4-Lite
// assumes the serial clock stops between frames and a complete word
// stays stable for several system clocks before the next one lands
//
// Summary of operation
// (R1) sixteen-bit shift register, whole word before decode
// (R2) four control bits, then 8/10/12 code bits
// (R3) host shifts msb first, bit 15 first
// (R4) bits 15 and 14 pick the channel
// (R5) bit 13 is range doubling, stored per channel
// (R6) range bit zero unity, one doubled
// (R7) bit 12 selects buffered reference when one
// (R8) reference setting touches only the addressed channel
// (R9) code is straight unsigned binary
// (R10) power-on clears input and converter registers
// (R11) after reset: normal, unbuffered, unity, zero output
// (R12) power-down switches all outputs to high impedance
// (R13) data sampled on falling clock while framed
// (R14) frame select early release discards the word
// (R15) complete word lands in addressed input register
// (R16) load low: converter registers follow inputs
// (R17) address 00 A, 01 B, 10 C, 11 D
// (R18) short codes use the top data bits
`timescale 1ns/1ps
module qdac_loader
  import qdac_pkg::*;
#(
  parameter int unsigned RES = 12 // code width: 8, 10 or 12
) (
  input wire logic clk,                     // system clock, 25 MHz
  input wire logic sys_rst,                 // async reset, active high
  input wire logic sclk,                    // serial link clock
  input wire logic frame_sel_n,             // frame select, active low
  input wire logic sdata,                   // serial data
  input wire logic load_outputs_n,          // load pin, active low
  input wire logic powerdown_n,             // power-down pin, active low
  input wire logic [31:0] s_axi_awaddr,     // write address
  input wire logic s_axi_awvalid,           // write address valid
  output logic s_axi_awready,               // write address ready
  input wire logic [31:0] s_axi_wdata,      // write data
  input wire logic [3:0] s_axi_wstrb,       // write byte enables
  input wire logic s_axi_wvalid,            // write data valid
  output logic s_axi_wready,                // write data ready
  output logic [1:0] s_axi_bresp,           // write response
  output logic s_axi_bvalid,                // write response valid
  input wire logic s_axi_bready,            // write response ready
  input wire logic [31:0] s_axi_araddr,     // read address
  input wire logic s_axi_arvalid,           // read address valid
  output logic s_axi_arready,               // read address ready
  output logic [31:0] s_axi_rdata,          // read data
  output logic [1:0] s_axi_rresp,           // read response
  output logic s_axi_rvalid,                // read data valid
  input wire logic s_axi_rready,            // read data ready
  output logic [3:0][RES-1:0] dac_code_o,   // converter codes
  output logic [3:0] gain_o,                // range doubling per channel
  output logic [3:0] ref_buf_o,             // buffered reference per channel
  output logic out_en_o                     // low: outputs high impedance
);
  ////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (!(RES == 8 || RES == 10 || RES == 12)) begin : g_bad_res
    $error("qdac_loader: RES must be 8, 10 or 12");
  end
  // low code bits that this variant ignores are forced to zero
  localparam logic [11:0] CODE_MASK = 12'hFFF << (QDAC_CODE_BITS - RES);
  ////////////////////////////////////////////////////////////////////
  // whole state of the clk domain
  typedef struct packed {
    qdac_chan_t [3:0] inreg;  // input registers
    qdac_chan_t [3:0] dacreg; // converter registers
    logic [3:0] pend;         // input changed since last transfer
    logic tog_seen;           // last word toggle consumed
    logic [7:0] words;        // complete words received, wraps
    logic sw_pd;              // software power-down
    logic sw_load;            // one-cycle software load
    logic out_en;             // output stage enabled
    logic aw_have;            // write address held
    logic [7:0] awaddr;       // held write address
    logic w_have;             // write data held
    logic [31:0] wdata;       // held write data
    logic [3:0] wstrb;        // held byte enables
    logic awready;            // registered ready
    logic wready;             // registered ready
    logic bvalid;             // write answer pending
    logic [1:0] bresp;        // write answer code
    logic arready;            // registered ready
    logic rvalid;             // read answer pending
    logic [1:0] rresp;        // read answer code
    logic [31:0] rdata;       // read answer data
  } qdac_state_t;
  qdac_state_t st_r;
  qdac_state_t st_nxt;
  // link side wires
  logic [15:0] link_word;   // stable while its toggle is pending
  logic link_tog;           // link domain toggle
  logic [2:0] pin_sync;     // synchronised toggle and pins
  logic word_evt;           // new word seen this cycle
  logic load_act;           // transfer inputs to converter registers
  logic [1:0] sel;          // addressed channel
  qdac_chan_t word_chan;    // decoded channel settings
  ////////////////////////////////////////////////////////////////////
  // serial receiver in the link clock domain
  qdac_link_rx u_rx (
    .sclk(sclk),
    .sys_rst(sys_rst),
    .frame_sel_n(frame_sel_n),
    .sdata(sdata),
    .word_o(link_word),
    .done_tog_o(link_tog)
  );
  // two flops for the toggle and both pins; pins rest inactive
  qdac_sync2 #(
    .W(3),
    .RST_VAL({QDAC_PIN_RST, 1'b0})
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d_i({powerdown_n, load_outputs_n, link_tog}),
    .q_o(pin_sync)
  );
  ////////////////////////////////////////////////////////////////////
  // word decode; the word is only read when its toggle arrives, by
  // which time it has been still for at least two system clocks
  assign word_evt = pin_sync[0] ^ st_r.tog_seen;
  assign sel = link_word[QDAC_SEL_HI:QDAC_SEL_LO]; // R4 R17
  assign word_chan.gain = link_word[QDAC_GAIN_BIT]; // R5 R6
  assign word_chan.buf_en = link_word[QDAC_BUF_BIT]; // R7
  // code kept as unsigned binary, low unused bits dropped
  assign word_chan.code = link_word[QDAC_CODE_MSB:0] & CODE_MASK; // R2 R9 R18
  // load pin held low or a software load moves pending inputs
  assign load_act = ~pin_sync[1] | st_r.sw_load; // R16
  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sw_load = 1'b0;
    // transfer first, so a word landing this cycle stays pending
    for (int i = 0; i < QDAC_CHANNELS; i++) begin
      if (load_act && st_r.pend[i]) begin
        st_nxt.dacreg[i] = st_r.inreg[i]; // R16
        st_nxt.pend[i] = 1'b0;
      end
    end
    // complete word: only the addressed channel changes
    if (word_evt) begin
      st_nxt.tog_seen = pin_sync[0];
      st_nxt.inreg[sel] = word_chan; // R15 R8
      st_nxt.pend[sel] = 1'b1;
      st_nxt.words = st_r.words + 8'h01;
    end
    // pin or software puts all four outputs in high impedance
    st_nxt.out_en = pin_sync[2] & ~st_r.sw_pd; // R12
    //////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    // answer retires first; a new write waits for it
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // both halves held: perform the write and answer
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (st_r.awaddr == QDAC_CTRL_OFS) begin
        st_nxt.bresp = QDAC_RESP_OKAY;
        // only the low byte holds control bits
        if (st_r.wstrb[0]) begin
          st_nxt.sw_pd = st_r.wdata[QDAC_CTRL_PD_BIT];
          st_nxt.sw_load = st_r.wdata[QDAC_CTRL_LOAD_BIT];
        end
      end else begin
        // status and channel registers are read only
        st_nxt.bresp = QDAC_RESP_SLVERR;
      end
    end
    // readies drop while a half is held or an answer waits
    st_nxt.awready = ~st_nxt.aw_have & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_have & ~st_nxt.bvalid;
    //////////////////////////////////////////////////////////////////
    // read channel: one read under way at a time
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = QDAC_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr[7:0] == QDAC_CTRL_OFS) begin
        // software load is a pulse and reads back as zero
        st_nxt.rdata[QDAC_CTRL_PD_BIT] = st_r.sw_pd;
      end else if (s_axi_araddr[7:0] == QDAC_STAT_OFS) begin
        // live view of the output stage and the load pin
        st_nxt.rdata[QDAC_STAT_PD_BIT] = ~st_r.out_en;
        st_nxt.rdata[QDAC_STAT_LOAD_BIT] = pin_sync[1];
        st_nxt.rdata[QDAC_STAT_CNT_LSB +: 8] = st_r.words;
      end else if ((s_axi_araddr[7:0] & QDAC_BANK_MASK) == QDAC_INREG_OFS) begin
        // input register bank, one word per channel
        st_nxt.rdata[13:0] = st_r.inreg[s_axi_araddr[3:2]];
      end else if ((s_axi_araddr[7:0] & QDAC_BANK_MASK) == QDAC_DACREG_OFS) begin
        // converter register bank, one word per channel
        st_nxt.rdata[13:0] = st_r.dacreg[s_axi_araddr[3:2]];
      end else begin
        // unmapped: error answer, data zero
        st_nxt.rresp = QDAC_RESP_SLVERR;
      end
    end
    st_nxt.arready = ~st_nxt.rvalid;
  end
  ////////////////////////////////////////////////////////////////////
  // state register; everything clears to zero, which is the
  // power-on picture of unity range, unbuffered, code zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0; // R10 R11
    end else begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // outputs, straight from the state register
  for (genvar c = 0; c < QDAC_CHANNELS; c++) begin : g_chan
    assign dac_code_o[c] = st_r.dacreg[c].code[QDAC_CODE_MSB -: RES]; // R18
    assign gain_o[c] = st_r.dacreg[c].gain; // R6
    assign ref_buf_o[c] = st_r.dacreg[c].buf_en; // R7
  end
  assign out_en_o = st_r.out_en; // R12
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
endmodule // qdac_loader

// ---- testbench/qdac_loader_monitor.sv ----
// checker for the quad converter loader: timing relations at the ports
// assumes it is bound into qdac_loader and sees one system clock domain
`timescale 1ns/1ps
module qdac_loader_monitor
  import qdac_pkg::*;
#(
  parameter int unsigned RES = 12 // code width
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic powerdown_n, // power-down pin
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [3:0][RES-1:0] dac_code_o, // converter codes
  input wire logic [3:0] gain_o, // range doubling
  input wire logic [3:0] ref_buf_o, // buffered reference
  input wire logic out_en_o // output enable
);
  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  // both write halves taken at one edge
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // pin held low long enough to cross the synchroniser
  sequence pin_low_s;
    !powerdown_n [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////
  reset_zero_a: assert property ($fell(sys_rst) |-> dac_code_o == '0 && gain_o == 4'h0
    && ref_buf_o == 4'h0) else $error("outputs not cleared by reset");
  write_answer_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  read_error_a: assert property (s_axi_rvalid && s_axi_rresp == QDAC_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
  pin_down_a: assert property (pin_low_s |-> !out_en_o)
    else $error("outputs driven while pin low");
  pin_up_a: assert property ($rose(out_en_o) |-> $past(powerdown_n))
    else $error("outputs enabled with pin low");
endmodule // qdac_loader_monitor

bind qdac_loader qdac_loader_monitor #(.RES(RES)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .powerdown_n(powerdown_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
  .dac_code_o(dac_code_o), .gain_o(gain_o), .ref_buf_o(ref_buf_o), .out_en_o(out_en_o)
);

// ---- testbench/qdac_host_model.sv ----
// host serial master: sends one word per call on a 48 ns serial clock
// assumes the caller waits for send to return before the next frame
`timescale 1ns/1ps
module qdac_host_model (
  output logic sclk, // serial clock, idles low between frames
  output logic frame_sel_n, // frame select, active low
  output logic sdata // serial data
);
  // idle state: clock still, frame closed
  initial begin
    sclk = 1'b0;
    frame_sel_n = 1'b1;
    sdata = 1'b1;
  end
  // nb below 16 closes the frame early on purpose
  task automatic send(input logic [15:0] w, input int nb);
    #7;
    frame_sel_n = 1'b0;
    #24;
    for (int i = 0; i < nb; i++) begin
      sdata = w[15-i];
      sclk = 1'b1;
      #24;
      sclk = 1'b0;
      #24;
    end
    frame_sel_n = 1'b1;
    sdata = ~sdata; // a released line must not keep its last level
    #800;
  endtask
endmodule // qdac_host_model

// ---- testbench/test_qdac_loader.sv ----
// self-checking bench for the quad converter loader, 10-bit variant
// assumes the host model drives the link and AXI4-Lite runs on clk
`timescale 1ns/1ps
module test_qdac_loader
  import qdac_pkg::*;
;
  localparam int unsigned TB_RES = 10; // short code exercises top-bit use
  logic clk, sys_rst, load_outputs_n, powerdown_n; // clock, reset, pins
  logic sclk, frame_sel_n, sdata; // serial link from host model
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata; // bus words
  logic [3:0] s_axi_wstrb, gain_o, ref_buf_o; // strobes, per-channel flags
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // write halves
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // handshakes
  logic s_axi_rvalid, s_axi_rready, out_en_o; // read data, output enable
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  logic [3:0][TB_RES-1:0] dac_code_o; // converter codes
  logic [13:0] exp_in [4]; // expected input registers
  logic [13:0] exp_dac [4]; // expected converter registers
  int fails, check_count, words; // mismatches, comparisons, complete words sent
  ////////////////////////////////////////////////////////////////////
  qdac_host_model host (.sclk(sclk), .frame_sel_n(frame_sel_n), .sdata(sdata));
  qdac_loader #(.RES(TB_RES)) dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .sdata(sdata), .load_outputs_n(load_outputs_n),
    .powerdown_n(powerdown_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dac_code_o(dac_code_o), .gain_o(gain_o), .ref_buf_o(ref_buf_o), .out_en_o(out_en_o));
  ////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bank image of a channel: low two code bits read as zero
  function automatic logic [31:0] reg_img(input logic [13:0] v);
    return {18'h0, v[13:12], v[11:2], 2'b00};
  endfunction
  // write: address and data offered together, readiness seen before the edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge clk);
      n++;
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) fails++;
  endtask
  // read: address held until taken, data taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, rd;
    n = 0;
    rd = 1'b0;
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rd && n < 100) begin
      @(negedge clk);
      n++;
      ar = s_axi_arvalid & s_axi_arready;
      rd = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!rd) fails++;
  endtask
  // one serial word, then the expectation it implies
  task automatic put(input logic [1:0] c, input logic [13:0] v, input int nb);
    host.send({c, v}, nb);
    repeat (8) @(posedge clk);
    if (nb == 16) exp_in[c] = v;
    if (nb == 16) words++;
    if (nb == 16 && !load_outputs_n) exp_dac[c] = v;
  endtask
  // converter outputs against the model
  task automatic check_outs();
    for (int c = 0; c < 4; c++) begin
      check({22'h0, dac_code_o[c]}, {22'h0, exp_dac[c][11:2]});
      check({31'h0, gain_o[c]}, {31'h0, exp_dac[c][13]});
      check({31'h0, ref_buf_o[c]}, {31'h0, exp_dac[c][12]});
    end
  endtask
  // input registers read back over the bus
  task automatic check_in();
    logic [31:0] d;
    logic [1:0] r;
    for (int c = 0; c < 4; c++) begin
      axi_rd(QDAC_INREG_OFS + 8'(c * 4), d, r);
      check(d, reg_img(exp_in[c]));
      check({30'h0, r}, {30'h0, QDAC_RESP_OKAY});
    end
  endtask
  // closing verdict
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well beyond the expected run of some 28 us
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {sys_rst, load_outputs_n, powerdown_n, s_axi_bready, s_axi_rready} = 5'h1F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    check_count = 0;
    words = 0;
    void'($urandom(32'h5004));
    for (int c = 0; c < 4; c++) exp_in[c] = '0;
    for (int c = 0; c < 4; c++) exp_dac[c] = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check_outs();
    check_in();
    check({31'h0, out_en_o}, 32'h1);
    // first pass corner codes, second pass random words
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++)
        put(2'(c), p == 0 ? {c[1], c[0], {12{c[0]}}} : 14'($urandom), 16);
      check_outs();
      check_in();
      load_outputs_n <= 1'b0;
      repeat (6) @(posedge clk);
      for (int c = 0; c < 4; c++) exp_dac[c] = exp_in[c];
      check_outs();
      put(2'(p + 1), 14'($urandom), 16);
      check_outs();
      load_outputs_n <= 1'b1;
    end
    put(2'h1, 14'h3ABC, 9);
    check_in();
    put(2'h2, 14'h2555, 16);
    check_outs();
    axi_wr(QDAC_CTRL_OFS, 32'h2, r);
    check({30'h0, r}, {30'h0, QDAC_RESP_OKAY});
    repeat (3) @(posedge clk);
    exp_dac[2] = exp_in[2];
    check_outs();
    // converter bank read back, then word count and load pin in status
    axi_rd(QDAC_DACREG_OFS + 8'h08, d, r);
    check(d, reg_img(exp_dac[2]));
    axi_rd(QDAC_STAT_OFS, d, r);
    check(d, {16'h0, 8'(words), 8'h02});
    axi_rd(8'h08, d, r);
    check({30'h0, r}, {30'h0, QDAC_RESP_SLVERR});
    axi_wr(QDAC_STAT_OFS, 32'h1, r);
    check({30'h0, r}, {30'h0, QDAC_RESP_SLVERR});
    powerdown_n <= 1'b0;
    repeat (5) @(posedge clk);
    check({31'h0, out_en_o}, 32'h0);
    check_outs();
    powerdown_n <= 1'b1;
    repeat (5) @(posedge clk);
    check({31'h0, out_en_o}, 32'h1);
    axi_wr(QDAC_CTRL_OFS, 32'h1, r);
    repeat (2) @(posedge clk);
    check({31'h0, out_en_o}, 32'h0);
    axi_wr(QDAC_CTRL_OFS, 32'h0, r);
    repeat (2) @(posedge clk);
    check({31'h0, out_en_o}, 32'h1);
    finish_test();
  end
endmodule // test_qdac_loader
